//--- pfl_map.svh
`ifndef PFL_MAP_SVH
`define PFL_MAP_SVH
// register offsets on the plain register port
`define PFL_ADDR_INPUT    4'h0
`define PFL_ADDR_OUTPUT   4'h1
`define PFL_ADDR_DIR      4'h2
`define PFL_ADDR_IFG      4'h3
`define PFL_ADDR_IES      4'h4
`define PFL_ADDR_IE       4'h5
`define PFL_ADDR_SEL      4'h6
`define PFL_ADDR_PORT_DIS 4'h7
`define PFL_ADDR_FUSE     4'h8
// reset values
`define PFL_RST_BYTE      8'h00
// bit positions of special functions
`define PFL_BIT_ACLK      0
`define PFL_BIT_TCLK      1
`define PFL_BIT_CMP       2
`define PFL_BIT_CMP1      3
`define PFL_BIT_CMP2      4
`define PFL_BIT_OSC_RES   5
`define PFL_PIN_BITS      6
// fuse status field positions
`define PFL_FUSE_CHECK    0
`define PFL_FUSE_BYPASS   1
`define PFL_FUSE_SENSE    2
`endif

//--- pfl_pkg.sv
package pfl_pkg;
  typedef logic [7:0] pfl_byte_t;
  typedef enum logic [1:0] {
    PFL_FUSE_IDLE   = 2'b00,
    PFL_FUSE_ACTIVE = 2'b01,
    PFL_FUSE_DONE   = 2'b10,
    PFL_FUSE_LOCKED = 2'b11
  } pfl_fuse_state_e;
endpackage : pfl_pkg

//--- pfl_pin_if.sv
`timescale 1ns/1ps
interface pfl_pin_if;
  logic [7:0] sel;
  logic [7:0] dir;
  logic [7:0] out_latch;
  logic [7:0] pad_in;
  logic [7:0] port_dis;
  logic [7:0] alt_out;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  logic [7:0] in_seen;
  modport ctl (output sel, dir, out_latch, pad_in, port_dis, alt_out,
               input pad_out, pad_oe_n, in_seen);
  modport mux (input sel, dir, out_latch, pad_in, port_dis, alt_out,
               output pad_out, pad_oe_n, in_seen);
endinterface : pfl_pin_if

//--- pfl_pad_mux.sv
`timescale 1ns/1ps
`include "pfl_map.svh"
module pfl_pad_mux (
  pfl_pin_if.mux pins  // per-bit pad control
);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      if (g < `PFL_PIN_BITS) begin : g_pin
        assign pins.pad_oe_n[g] = ~pins.dir[g];
        assign pins.pad_out[g]  = pins.sel[g] ? pins.alt_out[g]
                                              : pins.out_latch[g];
        assign pins.in_seen[g]  = pins.port_dis[g] ? 1'b0 : pins.pad_in[g];
      end else begin : g_nopin
        // unbonded: no pad, input reads the latch-free level low
        assign pins.pad_oe_n[g] = 1'b1;
        assign pins.pad_out[g]  = 1'b0;
        assign pins.in_seen[g]  = 1'b0;
      end
    end
  endgenerate
endmodule : pfl_pad_mux

//--- pfl_fuse_check.sv
`timescale 1ns/1ps
`include "pfl_map.svh"
module pfl_fuse_check (
  input  wire logic clock_i,      // system clock
  input  wire logic rstn_i,       // power-on reset, active low
  input  wire logic test_pin_i,   // test pin level
  input  wire logic test_access_i,// test port access pulse
  input  wire logic fuse_blown_i, // fuse state
  output logic      check_o,      // fuse-check mode active
  output logic      sense_o,      // sense current enable
  output logic      bypass_o,     // test logic in bypass
  output logic      grant_o       // access accepted
);
  pfl_pkg::pfl_fuse_state_e state_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= pfl_pkg::PFL_FUSE_IDLE;
    end else begin
      case (state_reg)
        pfl_pkg::PFL_FUSE_IDLE: begin
          if (fuse_blown_i) begin
            state_reg <= pfl_pkg::PFL_FUSE_LOCKED;
          end else if (test_access_i) begin
            state_reg <= pfl_pkg::PFL_FUSE_ACTIVE;
          end
        end
        pfl_pkg::PFL_FUSE_ACTIVE: begin
          if (fuse_blown_i) begin
            state_reg <= pfl_pkg::PFL_FUSE_LOCKED;
          end else if (!test_pin_i) begin
            state_reg <= pfl_pkg::PFL_FUSE_DONE;
          end
        end
        pfl_pkg::PFL_FUSE_DONE: begin
          if (fuse_blown_i) begin
            state_reg <= pfl_pkg::PFL_FUSE_LOCKED;
          end
        end
        default: state_reg <= pfl_pkg::PFL_FUSE_LOCKED;
      endcase
    end
  end
  assign check_o  = (state_reg == pfl_pkg::PFL_FUSE_ACTIVE);
  assign sense_o  = check_o & ~fuse_blown_i;
  assign bypass_o = (state_reg == pfl_pkg::PFL_FUSE_LOCKED) | fuse_blown_i;
  assign grant_o  = test_access_i & ~bypass_o;

  property p_fuse_lock;
    @(posedge clock_i) disable iff (!rstn_i)
      (state_reg == pfl_pkg::PFL_FUSE_LOCKED) |=> (state_reg == pfl_pkg::PFL_FUSE_LOCKED);
  endproperty
  a_fuse_lock: assert property (p_fuse_lock) else $error("fuse lock left");
  property p_fuse_end;
    @(posedge clock_i) disable iff (!rstn_i)
      (check_o && !test_pin_i && !fuse_blown_i) |=> !check_o && !sense_o;
  endproperty
  a_fuse_end: assert property (p_fuse_end) else $error("check not ended");
  property p_fuse_enter;
    @(posedge clock_i) disable iff (!rstn_i)
      (state_reg == pfl_pkg::PFL_FUSE_IDLE && test_access_i && !fuse_blown_i) |=> sense_o;
  endproperty
  a_fuse_enter: assert property (p_fuse_enter) else $error("no check mode");
  property p_fuse_refuse;
    @(posedge clock_i) disable iff (!rstn_i)
      fuse_blown_i |=> !check_o && !sense_o;
  endproperty
  a_fuse_refuse: assert property (p_fuse_refuse) else $error("blown fuse checked");
endmodule : pfl_fuse_check

//--- pfl_port_top.sv
`timescale 1ns/1ps
`include "pfl_map.svh"
module pfl_port_top (
  input  wire logic       clock_i,         // 250 MHz system clock
  input  wire logic       rstn_i,          // asynchronous reset, active low
  input  wire logic [3:0] addr_i,          // register address
  input  wire logic [7:0] wdata_i,         // write data
  input  wire logic       wr_i,            // write strobe
  input  wire logic       rd_i,            // read strobe
  output logic      [7:0] rdata_o,         // read data, cycle after rd_i
  input  wire logic [7:0] pad_in_i,        // pad input levels
  output logic      [7:0] pad_out_o,       // pad output levels
  output logic      [7:0] pad_oe_n_o,      // pad output enable, low drives
  input  wire logic       aux_clock_i,     // auxiliary clock for bit 0
  input  wire logic       comparator_result_i, // comparator result
  input  wire logic       compare_out_1_i, // timer compare output 1
  input  wire logic       compare_out_2_i, // timer compare output 2
  output logic            timer_ext_clock_in_o, // timer external clock
  output logic            capture0_input_b_o,   // timer capture input b
  output logic      [7:0] pin_irq_request_o, // per-bit interrupt requests
  output logic            irq_o,           // combined interrupt, level
  input  wire logic       test_pin_i,      // test pin level
  input  wire logic       test_access_i,   // test port access pulse
  input  wire logic       fuse_blown_i,    // fuse is blown
  output logic            fuse_check_o,    // fuse-check mode active
  output logic            fuse_sense_o,    // fuse sense current on
  output logic            test_bypass_o,   // test logic bypass
  output logic            test_grant_o     // test access accepted
);
  pfl_pkg::pfl_byte_t pin_function_select_reg;
  pfl_pkg::pfl_byte_t pin_direction_reg;
  pfl_pkg::pfl_byte_t pin_output_latch_reg;
  pfl_pkg::pfl_byte_t pin_irq_enable_reg;
  pfl_pkg::pfl_byte_t pin_irq_flag_reg;
  pfl_pkg::pfl_byte_t pin_edge_select_reg;
  pfl_pkg::pfl_byte_t comparator_port_disable_reg;
  pfl_pkg::pfl_byte_t pin_input_read_reg;
  pfl_pkg::pfl_byte_t in_prev_reg;
  pfl_pkg::pfl_byte_t edge_hit;
  pfl_pkg::pfl_byte_t alt_out;
  logic         [7:0] rdata_next;
  logic               fuse_check;
  logic               fuse_sense;
  logic               fuse_bypass;
  logic               primed_reg;
  pfl_pin_if          pins ();

  // module outputs for selected bits
  always_comb begin
    alt_out                 = 8'h00;
    alt_out[`PFL_BIT_ACLK]  = aux_clock_i;
    alt_out[`PFL_BIT_TCLK]  = 1'b0;
    alt_out[`PFL_BIT_CMP]   = comparator_result_i;
    alt_out[`PFL_BIT_CMP1]  = compare_out_1_i;
    alt_out[`PFL_BIT_CMP2]  = compare_out_2_i;
    alt_out[`PFL_BIT_OSC_RES] = 1'b0;
  end

  assign pins.sel       = pin_function_select_reg;
  assign pins.dir       = pin_direction_reg;
  assign pins.out_latch = pin_output_latch_reg;
  assign pins.pad_in    = pad_in_i;
  assign pins.port_dis  = comparator_port_disable_reg;
  assign pins.alt_out   = alt_out;

  pfl_pad_mux u_mux (
    .pins (pins.mux)
  );

  assign pad_out_o  = pins.pad_out;
  assign pad_oe_n_o = pins.pad_oe_n;

  // timer inputs taken from the isolated pin level
  assign timer_ext_clock_in_o = pins.in_seen[`PFL_BIT_TCLK];
  assign capture0_input_b_o   = pins.in_seen[`PFL_BIT_CMP];

  // input sampling and edge history
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_input_read_reg <= `PFL_RST_BYTE;
      in_prev_reg        <= `PFL_RST_BYTE;
      primed_reg         <= 1'b0;
    end else begin
      // first sample seeds both stages, so no false edge follows reset
      pin_input_read_reg <= pins.in_seen;
      in_prev_reg        <= primed_reg ? pin_input_read_reg : pins.in_seen;
      primed_reg         <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_edge
      if (g < `PFL_PIN_BITS) begin : g_pin
        // an isolated input never flags, even as the isolation cuts in
        assign edge_hit[g] = ~comparator_port_disable_reg[g] & (pin_edge_select_reg[g]
                           ? (in_prev_reg[g] & ~pin_input_read_reg[g])
                           : (~in_prev_reg[g] & pin_input_read_reg[g]));
      end else begin : g_soft
        assign edge_hit[g] = 1'b0;
      end
    end
  endgenerate

  // control registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_function_select_reg     <= `PFL_RST_BYTE;
      pin_direction_reg           <= `PFL_RST_BYTE;
      pin_output_latch_reg        <= `PFL_RST_BYTE;
      pin_irq_enable_reg          <= `PFL_RST_BYTE;
      pin_edge_select_reg         <= `PFL_RST_BYTE;
      comparator_port_disable_reg <= `PFL_RST_BYTE;
    end else if (wr_i) begin
      if (addr_i == `PFL_ADDR_OUTPUT) begin
        pin_output_latch_reg <= wdata_i;
      end else if (addr_i == `PFL_ADDR_DIR) begin
        pin_direction_reg <= wdata_i;
      end else if (addr_i == `PFL_ADDR_IES) begin
        pin_edge_select_reg <= wdata_i;
      end else if (addr_i == `PFL_ADDR_IE) begin
        pin_irq_enable_reg <= wdata_i;
      end else if (addr_i == `PFL_ADDR_SEL) begin
        pin_function_select_reg <= wdata_i;
      end else if (addr_i == `PFL_ADDR_PORT_DIS) begin
        comparator_port_disable_reg <= wdata_i;
      end
    end
  end

  // flags: software writes the value; an edge in the same cycle still sets
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_irq_flag_reg <= `PFL_RST_BYTE;
    end else if (wr_i && addr_i == `PFL_ADDR_IFG) begin
      pin_irq_flag_reg <= wdata_i | edge_hit;
    end else begin
      pin_irq_flag_reg <= pin_irq_flag_reg | edge_hit;
    end
  end

  assign pin_irq_request_o = pin_irq_flag_reg & pin_irq_enable_reg;
  assign irq_o             = |pin_irq_request_o;

  // read path
  always_comb begin
    rdata_next = 8'h00;
    if (addr_i == `PFL_ADDR_INPUT) begin
      rdata_next = pin_input_read_reg;
    end else if (addr_i == `PFL_ADDR_OUTPUT) begin
      rdata_next = pin_output_latch_reg;
    end else if (addr_i == `PFL_ADDR_DIR) begin
      rdata_next = pin_direction_reg;
    end else if (addr_i == `PFL_ADDR_IFG) begin
      rdata_next = pin_irq_flag_reg;
    end else if (addr_i == `PFL_ADDR_IES) begin
      rdata_next = pin_edge_select_reg;
    end else if (addr_i == `PFL_ADDR_IE) begin
      rdata_next = pin_irq_enable_reg;
    end else if (addr_i == `PFL_ADDR_SEL) begin
      rdata_next = pin_function_select_reg;
    end else if (addr_i == `PFL_ADDR_PORT_DIS) begin
      rdata_next = comparator_port_disable_reg;
    end else if (addr_i == `PFL_ADDR_FUSE) begin
      rdata_next[`PFL_FUSE_CHECK]  = fuse_check;
      rdata_next[`PFL_FUSE_BYPASS] = fuse_bypass;
      rdata_next[`PFL_FUSE_SENSE]  = fuse_sense;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `PFL_RST_BYTE;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  pfl_fuse_check u_fuse (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .test_pin_i    (test_pin_i),
    .test_access_i (test_access_i),
    .fuse_blown_i  (fuse_blown_i),
    .check_o       (fuse_check),
    .sense_o       (fuse_sense),
    .bypass_o      (fuse_bypass),
    .grant_o       (test_grant_o)
  );
  assign fuse_check_o  = fuse_check;
  assign fuse_sense_o  = fuse_sense;
  assign test_bypass_o = fuse_bypass;

  property p_dir;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_DIR) |=> (pad_oe_n_o[5:0] == ~$past(wdata_i[5:0]));
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_aclk;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_ACLK] |-> pad_out_o[`PFL_BIT_ACLK] == aux_clock_i;
  endproperty
  a_aclk: assert property (p_aclk) else $error("aux clock not on pin");
  property p_tclk;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_TCLK] |-> !pad_out_o[`PFL_BIT_TCLK];
  endproperty
  a_tclk: assert property (p_tclk) else $error("bit 1 output not low");
  property p_cmp;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_CMP] |->
        pad_out_o[`PFL_BIT_CMP] == comparator_result_i;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator not on pin");
  property p_soft;
    @(posedge clock_i) disable iff (!rstn_i)
      !(wr_i && addr_i == `PFL_ADDR_IFG) |=> $stable(pin_irq_flag_reg[7:6]);
  endproperty
  a_soft: assert property (p_soft) else $error("soft flag changed");
  property p_req;
    @(posedge clock_i) disable iff (!rstn_i)
      (pin_irq_flag_reg != 8'h00 && pin_irq_enable_reg == 8'hFF) |-> irq_o;
  endproperty
  a_req: assert property (p_req) else $error("request missing");
  property p_rise;
    @(posedge clock_i) disable iff (!rstn_i)
      (!pin_edge_select_reg[0] && !comparator_port_disable_reg[0] && !in_prev_reg[0]
        && pin_input_read_reg[0])
        |=> pin_irq_flag_reg[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge lost");
  property p_isolate;
    @(posedge clock_i) disable iff (!rstn_i)
      comparator_port_disable_reg[3] ##1 comparator_port_disable_reg[3]
        |-> !pin_input_read_reg[3];
  endproperty
  a_isolate: assert property (p_isolate) else $error("disabled input leaks");
  property p_cmp1;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_CMP1] |-> pad_out_o[`PFL_BIT_CMP1] == compare_out_1_i;
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("compare output 1 not on pin");
  property p_cmp2;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_CMP2] |-> pad_out_o[`PFL_BIT_CMP2] == compare_out_2_i;
  endproperty
  a_cmp2: assert property (p_cmp2) else $error("compare output 2 not on pin");
  property p_osc_res;
    @(posedge clock_i) disable iff (!rstn_i)
      pin_function_select_reg[`PFL_BIT_OSC_RES] |-> !pad_out_o[`PFL_BIT_OSC_RES];
  endproperty
  a_osc_res: assert property (p_osc_res) else $error("bit 5 output not low");
  property p_latch;
    @(posedge clock_i) disable iff (!rstn_i)
      !pin_function_select_reg[`PFL_BIT_ACLK] |->
        pad_out_o[`PFL_BIT_ACLK] == pin_output_latch_reg[`PFL_BIT_ACLK];
  endproperty
  a_latch: assert property (p_latch) else $error("latch not on pin");
  property p_oe_hold;
    @(posedge clock_i) disable iff (!rstn_i)
      !(wr_i && addr_i == `PFL_ADDR_DIR) |=> $stable(pad_oe_n_o);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("direction moved");
  property p_tclk_in;
    @(posedge clock_i) disable iff (!rstn_i)
      timer_ext_clock_in_o ==
        (pad_in_i[`PFL_BIT_TCLK] & !comparator_port_disable_reg[`PFL_BIT_TCLK]);
  endproperty
  a_tclk_in: assert property (p_tclk_in) else $error("timer clock not routed");
  property p_capb;
    @(posedge clock_i) disable iff (!rstn_i)
      capture0_input_b_o ==
        (pad_in_i[`PFL_BIT_CMP] & !comparator_port_disable_reg[`PFL_BIT_CMP]);
  endproperty
  a_capb: assert property (p_capb) else $error("capture input not routed");
  property p_latch_keep;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_OUTPUT) |=> pin_output_latch_reg == $past(wdata_i);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch bits lost");
  property p_sel_keep;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_SEL) |=> pin_function_select_reg == $past(wdata_i);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("select bits lost");
  property p_ie_keep;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_IE) |=> pin_irq_enable_reg == $past(wdata_i);
  endproperty
  a_ie_keep: assert property (p_ie_keep) else $error("enable bits lost");
  property p_rd_latch;
    @(posedge clock_i) disable iff (!rstn_i)
      (rd_i && addr_i == `PFL_ADDR_OUTPUT) |=> rdata_o == $past(pin_output_latch_reg);
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("latch read wrong");
  property p_soft_write;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_IFG) |=> pin_irq_flag_reg[7:6] == $past(wdata_i[7:6]);
  endproperty
  a_soft_write: assert property (p_soft_write) else $error("soft flag not written");
  property p_soft_irq;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_IFG && wdata_i[7] && pin_irq_enable_reg[7])
        |=> pin_irq_request_o[7] && irq_o;
  endproperty
  a_soft_irq: assert property (p_soft_irq) else $error("soft interrupt missing");
  property p_clear;
    @(posedge clock_i) disable iff (!rstn_i)
      (wr_i && addr_i == `PFL_ADDR_IFG && wdata_i == 8'h00 && edge_hit == 8'h00)
        |=> pin_irq_flag_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_fall;
    @(posedge clock_i) disable iff (!rstn_i)
      (pin_edge_select_reg[5] && !comparator_port_disable_reg[5]
        && in_prev_reg[5] && !pin_input_read_reg[5])
        |=> pin_irq_flag_reg[5];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge lost");
  property p_isolate_flag;
    @(posedge clock_i) disable iff (!rstn_i)
      (comparator_port_disable_reg[2] && !(wr_i && addr_i == `PFL_ADDR_IFG))
        |=> $stable(pin_irq_flag_reg[2]);
  endproperty
  a_isolate_flag: assert property (p_isolate_flag) else $error("isolated pin flagged");
  property p_bypass;
    @(posedge clock_i) disable iff (!rstn_i)
      fuse_blown_i |-> test_bypass_o && !test_grant_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("blown fuse not bypassed");
endmodule : pfl_port_top

//--- pfl_far_model.sv
`timescale 1ns/1ps
module pfl_far_model (
  input  wire logic       clock_i,     // system clock
  input  wire logic       rstn_i,      // reset, active low
  input  wire logic [7:0] ext_lvl_i,   // level forced by outside parts
  input  wire logic [7:0] pad_out_i,   // device pad data
  input  wire logic [7:0] pad_oe_n_i,  // device drive enable, low drives
  output logic      [7:0] pad_in_o,    // resolved pin level
  output logic            aux_clock_o  // auxiliary clock source
);
  // device wins where it drives, outside source elsewhere
  assign pad_in_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_lvl_i);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aux_clock_o <= 1'b0;
    end else begin
      aux_clock_o <= ~aux_clock_o;
    end
  end
endmodule : pfl_far_model

//--- tb_top.sv
`timescale 1ns/1ps
`include "pfl_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic        clock_i, rstn_i, wr_i, rd_i, cmp_r, c1_r, c2_r;
  logic        test_pin, test_acc, blown, aux, tclk, capb, irq;
  logic        chk, sense, byp, grant;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o, ext, pad_out, oe_n, pad_in, req;
  logic [7:0]  d, s, dr, o, cp, a, b, es, e, lv;
  logic [31:0] seed = 32'h68E2;
  int          n_fail = 0;
  int          n_tests = 0;

  pfl_port_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(oe_n),
    .aux_clock_i(aux), .comparator_result_i(cmp_r), .compare_out_1_i(c1_r),
    .compare_out_2_i(c2_r), .timer_ext_clock_in_o(tclk),
    .capture0_input_b_o(capb), .pin_irq_request_o(req), .irq_o(irq),
    .test_pin_i(test_pin), .test_access_i(test_acc), .fuse_blown_i(blown),
    .fuse_check_o(chk), .fuse_sense_o(sense), .test_bypass_o(byp),
    .test_grant_o(grant));
  pfl_far_model far (.clock_i(clock_i), .rstn_i(rstn_i), .ext_lvl_i(ext),
    .pad_out_i(pad_out), .pad_oe_n_i(oe_n), .pad_in_o(pad_in),
    .aux_clock_o(aux));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  // expected pad data of bits 0 to 5
  function automatic logic [5:0] f_pad(logic [7:0] sl, ol, logic ax, cm, k1, k2);
    logic [5:0] r;
    r = ol[5:0];
    if (sl[0]) r[0] = ax;
    if (sl[1]) r[1] = 1'b0;
    if (sl[2]) r[2] = cm;
    if (sl[3]) r[3] = k1;
    if (sl[4]) r[4] = k2;
    if (sl[5]) r[5] = 1'b0;
    return r;
  endfunction : f_pad

  function automatic logic [7:0] f_edge(logic [7:0] sel_e, pa, pb);
    return ((~sel_e & ~pa & pb) | (sel_e & pa & ~pb)) & 8'h3F;
  endfunction : f_edge

  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clock_i);
    addr_i  <= ad;
    wdata_i <= dt;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(negedge clock_i);
    dt = rdata_o;
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask : ticks

  task automatic do_rst();
    rstn_i <= 1'b0;
    ticks(16);
    rstn_i <= 1'b1;
  endtask : do_rst

  task automatic pulse();
    @(posedge clock_i);
    test_acc <= 1'b1;
    @(negedge clock_i);
    e[0] = grant;
    @(posedge clock_i);
    test_acc <= 1'b0;
    ticks(3);
  endtask : pulse

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    n_fail++;
    test_done();
  end

  initial begin
    {rstn_i, wr_i, rd_i, cmp_r, c1_r, c2_r, test_pin, test_acc, blown} = '0;
    addr_i  = 4'h0;
    wdata_i = 8'h00;
    ext     = 8'h00;
    do_rst();
    @(negedge clock_i);
    `CHK(oe_n, 8'hFF)
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], d);
      `CHK(d, 8'h00)
    end
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      s  = xs();
      dr = xs();
      o  = xs();
      cp = xs();
      @(posedge clock_i);
      ext   <= xs();
      cmp_r <= seed[8];
      c1_r  <= seed[9];
      c2_r  <= seed[10];
      wr(`PFL_ADDR_SEL, s);
      wr(`PFL_ADDR_DIR, dr);
      wr(`PFL_ADDR_OUTPUT, o);
      wr(`PFL_ADDR_PORT_DIS, cp);
      wr(`PFL_ADDR_INPUT, 8'hFF);
      rd(`PFL_ADDR_SEL, d);
      `CHK(d, s)
      rd(`PFL_ADDR_DIR, d);
      `CHK(d, dr)
      rd(`PFL_ADDR_PORT_DIS, d);
      `CHK(d, cp)
      `CHK(oe_n, {2'b11, ~dr[5:0]})
      `CHK(pad_out[5:0], f_pad(s, o, aux, cmp_r, c1_r, c2_r))
      lv = (dr & {2'b00, f_pad(s, o, aux, cmp_r, c1_r, c2_r)}) | (~dr & ext);
      `CHK(tclk, lv[1] & ~cp[1])
      `CHK(capb, lv[2] & ~cp[2])
      rd(`PFL_ADDR_INPUT, d);
      `CHK(d[5:1], lv[5:1] & ~cp[5:1])
    end
    $display("test pin functions done");
    wr(`PFL_ADDR_PORT_DIS, 8'h00);
    wr(`PFL_ADDR_DIR, 8'h00);
    wr(`PFL_ADDR_SEL, 8'h00);
    wr(`PFL_ADDR_IE, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      es = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : xs();
      a  = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : xs();
      b  = (i < 2) ? ~a : xs();
      wr(`PFL_ADDR_IES, es);
      @(posedge clock_i);
      ext <= a;
      ticks(4);
      wr(`PFL_ADDR_IFG, 8'h00);
      @(posedge clock_i);
      ext <= b;
      ticks(4);
      e = f_edge(es, a, b);
      rd(`PFL_ADDR_IFG, d);
      `CHK(d, e)
      `CHK(req, e)
      `CHK(irq, |e)
    end
    wr(`PFL_ADDR_IE, 8'h00);
    @(negedge clock_i);
    `CHK(irq, 1'b0)
    $display("test edges done");
    wr(`PFL_ADDR_PORT_DIS, 8'h3F);
    wr(`PFL_ADDR_IFG, 8'h00);
    wr(`PFL_ADDR_IE, 8'hC0);
    @(posedge clock_i);
    ext <= ~ext;
    ticks(3);
    ext <= ~ext;
    ticks(4);
    rd(`PFL_ADDR_IFG, d);
    `CHK(d, 8'h00)
    wr(`PFL_ADDR_IFG, 8'hC0);
    rd(`PFL_ADDR_IFG, d);
    `CHK(d, 8'hC0)
    `CHK(req, 8'hC0)
    `CHK(irq, 1'b1)
    $display("test software flags done");
    @(posedge clock_i);
    test_pin <= 1'b1;
    pulse();
    `CHK(e[0], 1'b1)
    rd(`PFL_ADDR_FUSE, d);
    `CHK(d, 8'h05)
    `CHK({chk, sense}, 2'b11)
    @(posedge clock_i);
    test_pin <= 1'b0;
    ticks(3);
    rd(`PFL_ADDR_FUSE, d);
    `CHK(d, 8'h00)
    @(posedge clock_i);
    test_pin <= 1'b1;
    pulse();
    `CHK({chk, sense}, 2'b00)
    blown <= 1'b1;
    do_rst();
    pulse();
    rd(`PFL_ADDR_FUSE, d);
    `CHK(d, 8'h02)
    pulse();
    `CHK(e[0], 1'b0)
    `CHK({byp, sense}, 2'b10)
    $display("test fuse done");
    test_done();
  end
endmodule : tb_top
